// ---- emi_ctrl_regs.v ----
/*
 Software-visible interrupt enable and NAND flash control registers of an
 external memory interface, reached over AHB-Lite, with raw and masked
 interrupt status and the interrupt pulse toward the CPU.
 Assumes one AHB-Lite master with single word transfers; ECC engines
 and the access sequencer live outside; only the sequencer reports through ports.
*/
// Chosen here: the address map and the AHB-Lite register port.
`timescale 1ns/1ns
`include "emi_regs_defines.vh"

module emi_ctrl_regs
#(
  parameter HAS_WAIT_PIN = 1
)
(
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Memory side events
  input  wire        memory_wait_input,
  input  wire        ext_access_active,
  input  wire        line_trap_event,
  // Interrupt to CPU
  output reg         irq_pulse,
  // Chip select configuration
  output reg  [3:0]  flash_mode,
  output reg  [3:0]  parity_start,
  output reg         quad_code_start,
  output reg  [1:0]  quad_code_select,
  output reg         quad_error_locate_start,
  // Wait status
  output reg         wait_level
);
  // ==========================================================
  // Declarations
  reg  [`IRQ_WIDTH-1:0]       irq_enable;
  reg  [`IRQ_WIDTH-1:0]       irq_raw_status;
  reg  [`WAIT_LIMIT_WIDTH-1:0] extended_wait_limit;
  reg  [`CTRL_WIDTH-1:0]      control;
  reg                         wr_pend;
  reg                         rd_pend;
  reg  [11:0]                 addr_q;
  reg  [31:0]                 next_hrdata;
  reg  [`IRQ_WIDTH-1:0]       next_raw;
  reg  [`IRQ_WIDTH-1:0]       next_enable;
  reg  [`CTRL_WIDTH-1:0]      next_control;
  reg  [`WAIT_LIMIT_WIDTH-1:0] next_wait_limit;
  wire [11:0]                 haddr_word;
  wire [`IRQ_WIDTH-1:0]       irq_masked_status;
  wire [`IRQ_WIDTH-1:0]       masked_before;
  wire [`IRQ_WIDTH-1:0]       events;
  wire                        wait_sync;
  wire                        wait_rise;
  wire                        timeout_event;
  wire                        addr_phase;
  wire                        rd_ecc1;
  wire                        rd_quad;
  wire                        rd_err;
  wire [1:0]                  ecc1_idx;

  // ==========================================================
  // Event sources
  wait_edge_sync u_wait
  (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_in  (memory_wait_input),
    .level   (wait_sync),
    .rise    (wait_rise)
  );

  timeout_watch u_timeout
  (
    .clk_sys             (clk_sys),
    .rst                 (rst),
    .access_active       (ext_access_active),
    .wait_active         (wait_sync),
    .extended_wait_limit (extended_wait_limit),
    .timeout             (timeout_event)
  );

  // Without a wait pin no source exists, so events are forced off
  assign events[`IRQ_WAIT_RISE_BIT] = (HAS_WAIT_PIN != 0) & wait_rise;
  assign events[`IRQ_LINE_TRAP_BIT] = (HAS_WAIT_PIN != 0) & line_trap_event;
  assign events[`IRQ_TIMEOUT_BIT]   = (HAS_WAIT_PIN != 0) & timeout_event;

  assign irq_masked_status = irq_raw_status & irq_enable;
  assign masked_before     = irq_masked_status;

  // ==========================================================
  // AHB-Lite address phase capture
  assign addr_phase = hsel & hready & htrans[1];

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      addr_q    <= 12'h000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      // Zero wait states; response always OKAY
      wr_pend   <= addr_phase & hwrite;
      rd_pend   <= addr_phase & ~hwrite;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_phase)
        addr_q <= {haddr[11:2], 2'b00};
    end
  end

  // ==========================================================
  // Read data, taken from the address phase so hrdata is registered
  assign haddr_word = {haddr[11:2], 2'b00};

  // Built from next values: a read right behind a write must see that write
  always @*
  begin
    next_hrdata = 32'h0000_0000;
    if (haddr_word == `OFS_IRQ_RAW)
      next_hrdata = {29'h0, next_raw};
    else if (haddr_word == `OFS_IRQ_MASKED)
      next_hrdata = {29'h0, next_raw & next_enable};
    else if ((haddr_word == `OFS_IRQ_ENABLE_SET) || (haddr_word == `OFS_IRQ_ENABLE_CLR))
      next_hrdata = (HAS_WAIT_PIN != 0) ? {29'h0, next_enable} : 32'h0000_0000;
    else if (haddr_word == `OFS_NAND_CTRL)
      next_hrdata = {18'h0, next_control[13:8], 2'b00, next_control[5:0]};
    else if (haddr_word == `OFS_WAIT_LIMIT)
      next_hrdata = {24'h0, next_wait_limit};
  end

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      hrdata <= 32'h0000_0000;
    else if (addr_phase && !hwrite)
      hrdata <= next_hrdata;
  end

  // ==========================================================
  // Reads of result registers that clear start bits
  assign rd_ecc1  = addr_phase & ~hwrite & (haddr >= `OFS_ECC1_BASE) & (haddr <= `OFS_ECC1_LAST);
  assign rd_quad  = addr_phase & ~hwrite & (haddr >= `OFS_QUAD_CODE_BASE) & (haddr <= `OFS_QUAD_CODE_LAST);
  assign rd_err   = addr_phase & ~hwrite & (haddr >= `OFS_ERR_BASE) & (haddr <= `OFS_ERR_LAST);
  assign ecc1_idx = haddr[3:2];

  // ==========================================================
  // Register updates
  always @*
  begin
    next_raw     = irq_raw_status;
    next_enable  = irq_enable;
    next_control = control;
    next_wait_limit = extended_wait_limit;
    if (wr_pend && addr_q == `OFS_WAIT_LIMIT)
      next_wait_limit = hwdata[7:0];
    if (wr_pend && addr_q == `OFS_IRQ_RAW)
      next_raw = irq_raw_status & ~hwdata[2:0];
    else if (wr_pend && addr_q == `OFS_IRQ_MASKED)
      next_raw = irq_raw_status & ~hwdata[2:0];
    if (wr_pend && addr_q == `OFS_IRQ_ENABLE_SET && HAS_WAIT_PIN != 0)
      next_enable = irq_enable | hwdata[2:0];
    else if (wr_pend && addr_q == `OFS_IRQ_ENABLE_CLR && HAS_WAIT_PIN != 0)
      next_enable = irq_enable & ~hwdata[2:0];
    if (wr_pend && addr_q == `OFS_NAND_CTRL)
    begin
      next_control[3:0]   = hwdata[3:0];
      next_control[5:4]   = hwdata[5:4];
      next_control[7:6]   = 2'b00;
      // Start bits are only set by a write; zero keeps a running start
      next_control[11:8]  = control[11:8] | hwdata[11:8];
      next_control[12]    = control[12] | hwdata[12];
      next_control[13]    = control[13] | hwdata[13];
    end
    if (rd_ecc1)
      next_control[`CTRL_PARITY_LO + ecc1_idx] = 1'b0;
    if (rd_quad)
      next_control[`CTRL_QUAD_START] = 1'b0;
    if (rd_err)
      next_control[`CTRL_LOCATE_START] = 1'b0;
    // Hardware set beats a software clear in the same cycle
    next_raw = next_raw | events;
  end

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      irq_raw_status      <= 3'h0;
      irq_enable          <= `IRQ_ENABLE_RESET;
      control             <= `CTRL_RESET;
      extended_wait_limit <= `WAIT_LIMIT_RESET;
    end
    else
    begin
      irq_raw_status <= next_raw;
      irq_enable     <= next_enable;
      control        <= next_control;
      extended_wait_limit <= next_wait_limit;
    end
  end

  // ==========================================================
  // Outputs, all registered
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      irq_pulse               <= 1'b0;
      flash_mode              <= 4'h0;
      parity_start            <= 4'h0;
      quad_code_start         <= 1'b0;
      quad_code_select        <= 2'h0;
      quad_error_locate_start <= 1'b0;
      wait_level              <= 1'b0;
    end
    else
    begin
      // One pulse when any masked flag goes from clear to set
      irq_pulse               <= |((next_raw & next_enable) & ~masked_before);
      flash_mode              <= control[3:0];
      parity_start            <= control[11:8];
      quad_code_start         <= control[12];
      quad_code_select        <= control[5:4];
      quad_error_locate_start <= control[13];
      wait_level              <= wait_sync;
    end
  end
endmodule // emi_ctrl_regs

// ---- emi_regs_defines.vh ----
/*
 Constants for the external memory interface control register bank:
 register byte offsets, field positions and reset values.
 Assumes inclusion by bare name from the design files.
*/
`ifndef EMI_REGS_DEFINES_VH
`define EMI_REGS_DEFINES_VH

// ==========================================================
// Register byte offsets
`define OFS_IRQ_RAW         12'h040
`define OFS_IRQ_MASKED      12'h044
`define OFS_IRQ_ENABLE_SET  12'h048
`define OFS_IRQ_ENABLE_CLR  12'h04c
`define OFS_NAND_CTRL       12'h060
`define OFS_WAIT_LIMIT      12'h004
`define OFS_ECC1_BASE       12'h070
`define OFS_ECC1_LAST       12'h07c
`define OFS_QUAD_CODE_BASE  12'h0c0
`define OFS_QUAD_CODE_LAST  12'h0cc
`define OFS_ERR_BASE        12'h0d0
`define OFS_ERR_LAST        12'h0dc

// ==========================================================
// Interrupt bit positions
`define IRQ_TIMEOUT_BIT     0
`define IRQ_LINE_TRAP_BIT   1
`define IRQ_WAIT_RISE_BIT   2
`define IRQ_WIDTH           3

// ==========================================================
// Control field positions
`define CTRL_FLASH_MODE_LO  0
`define CTRL_FLASH_MODE_HI  3
`define CTRL_QUAD_SEL_LO    4
`define CTRL_QUAD_SEL_HI    5
`define CTRL_PARITY_LO      8
`define CTRL_PARITY_HI      11
`define CTRL_QUAD_START     12
`define CTRL_LOCATE_START   13
`define CTRL_WIDTH          14

// ==========================================================
// Reset values and limits
`define IRQ_ENABLE_RESET    3'h0
`define CTRL_RESET          14'h0000
`define WAIT_LIMIT_RESET    8'h80
`define WAIT_LIMIT_WIDTH    8

`endif

// ---- wait_edge_sync.v ----
/*
 Two-flop synchroniser for the external wait input with a rising edge
 detector behind the second stage.
 Assumes a level input from outside the clock domain.
*/
`timescale 1ns/1ns
module wait_edge_sync
(
  // Clock and reset
  input  wire clk_sys,
  input  wire rst,
  // Pin and results
  input  wire pin_in,
  output reg  level,
  output wire rise
);
  reg meta;
  reg level_d;

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      meta    <= 1'b0;
      level   <= 1'b0;
      level_d <= 1'b0;
    end
    else
    begin
      meta    <= pin_in;
      level   <= meta;
      level_d <= level;
    end
  end

  assign rise = level & ~level_d;
endmodule // wait_edge_sync

// ---- timeout_watch.v ----
/*
 Counts cycles that the synchronised wait input stays active during an
 extended asynchronous access and flags a single timeout per stretch of active wait.
 Assumes access_active is a level from the same clock domain.
*/
`timescale 1ns/1ns
`include "emi_regs_defines.vh"
module timeout_watch
(
  // Clock and reset
  input  wire                         clk_sys,
  input  wire                         rst,
  // Access monitor
  input  wire                         access_active,
  input  wire                         wait_active,
  input  wire [`WAIT_LIMIT_WIDTH-1:0] extended_wait_limit,
  output wire                         timeout
);
  reg [`WAIT_LIMIT_WIDTH-1:0] count;
  reg                         fired;

  // One pulse per stretch of active wait, even if wait stays high afterwards
  assign timeout = access_active & wait_active & ~fired & (count == extended_wait_limit);

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      count <= {`WAIT_LIMIT_WIDTH{1'b0}};
      fired <= 1'b0;
    end
    else if (!access_active || !wait_active)
    begin
      count <= {`WAIT_LIMIT_WIDTH{1'b0}};
      fired <= 1'b0;
    end
    else if (timeout)
      fired <= 1'b1;
    else if (!fired)
      count <= count + {{(`WAIT_LIMIT_WIDTH-1){1'b0}}, 1'b1};
  end
endmodule // timeout_watch

// ---- emi_ctrl_regs_props.sv ----
/*
 Concurrent checks for the control register bank, bound to its top ports.
 Assumes single-word AHB-Lite transfers and zero-wait answers.
*/
`timescale 1ns/1ns
module emi_ctrl_regs_props
(
  // Clock and reset
  input wire        clk_sys,
  input wire        rst,
  // Bus
  input wire        hsel,
  input wire [11:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  // Events and outputs
  input wire        memory_wait_input,
  input wire        irq_pulse,
  input wire [3:0]  flash_mode,
  input wire [3:0]  parity_start,
  input wire        quad_code_start,
  input wire [1:0]  quad_code_select,
  input wire        quad_error_locate_start,
  input wire        wait_level
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==========================================
  // Transfer steps
  sequence s_read_at_hi(logic [7:0] page);
    hsel && hready && htrans[1] && !hwrite && haddr[11:4] == page;
  endsequence
  sequence s_ctrl_write;
    (hsel && hready && htrans[1] && hwrite && haddr == 12'h060) ##1 1'b1;
  endsequence
  // ==========================================
  // Checks
  a_reset_zero: assert property ($past(rst) && !rst |-> flash_mode == 4'h0 && parity_start == 4'h0
    && !quad_code_start && quad_code_select == 2'h0 && !quad_error_locate_start && !irq_pulse)
    else $error("outputs not clear after reset");
  // Register updates at the data phase edge, the output flop one edge later
  a_mode_write: assert property (s_ctrl_write |-> ##2 flash_mode == $past(hwdata[3:0], 2))
    else $error("flash mode not taken from write");
  a_select_write: assert property (s_ctrl_write |-> ##2 quad_code_select == $past(hwdata[5:4], 2))
    else $error("quad select not taken from write");
  a_parity_clear: assert property (s_read_at_hi(8'h07) ##0 haddr[3:0] == 4'h0 |-> ##2 !parity_start[0])
    else $error("parity start kept after read");
  a_quad_clear: assert property (s_read_at_hi(8'h0c) |-> ##2 !quad_code_start)
    else $error("quad start kept after read");
  a_locate_clear: assert property (s_read_at_hi(8'h0d) |-> ##2 !quad_error_locate_start)
    else $error("locate start kept after read");
  a_pulse_single: assert property (irq_pulse |=> !irq_pulse)
    else $error("interrupt pulse too long");
  a_wait_sync: assert property (memory_wait_input [*3] |=> wait_level)
    else $error("wait level lags pin");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
endmodule // emi_ctrl_regs_props

bind emi_ctrl_regs emi_ctrl_regs_props i_emi_ctrl_regs_props
  (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .memory_wait_input(memory_wait_input), .irq_pulse(irq_pulse), .flash_mode(flash_mode),
   .parity_start(parity_start), .quad_code_start(quad_code_start), .quad_code_select(quad_code_select),
   .quad_error_locate_start(quad_error_locate_start), .wait_level(wait_level));

// ---- mem_side_model.sv ----
/*
 Memory side model: an extended access that holds the wait pin for a
 chosen number of cycles, and a one-cycle line trap event.
 Assumes commands come from the bench just after a rising edge.
*/
`timescale 1ns/1ns
module mem_side_model
(
  // Clock
  input  wire       clk_sys,
  // Commands
  input  wire       access_req,
  input  wire [7:0] stall_cycles,
  input  wire       trap_req,
  // Memory side
  output reg        memory_wait_input = 1'b0,
  output reg        ext_access_active = 1'b0,
  output reg        line_trap_event   = 1'b0
);
  reg [7:0] count = 8'h00;
  always @(posedge clk_sys)
  begin
    line_trap_event <= trap_req;
    // Wait and access drop together, so a long stall outlasts the limit
    if (access_req && !ext_access_active)
    begin
      ext_access_active <= 1'b1;
      memory_wait_input <= 1'b1;
      count             <= stall_cycles;
    end
    else if (count != 8'h00)
      count <= count - 8'h01;
    else
    begin
      ext_access_active <= 1'b0;
      memory_wait_input <= 1'b0;
    end
  end
endmodule // mem_side_model

// ---- emi_ctrl_regs_tb.sv ----
/*
 Self-checking bench for the control register bank: table of register
 writes and reads, then start clearing, event and reset cases.
 Assumes the bound checker and the memory side model.
*/
`timescale 1ns/1ns
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin $display("Error %s exp %h got %h", n, e, s); err_count++; end end
module emi_ctrl_regs_tb;
  logic        clk_sys = 0, rst = 1, hsel = 0, hwrite = 0, access_req = 0, trap_req = 0;
  logic [11:0] haddr = 0;
  logic [1:0]  htrans = 0, quad_code_select;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 0, hrdata, q;
  logic [7:0]  stall_cycles = 0;
  logic [3:0]  flash_mode, parity_start, e4;
  logic        hreadyout, hresp, irq_pulse, quad_code_start, quad_error_locate_start, wait_level;
  wire         hready, memory_wait_input, ext_access_active, line_trap_event;
  int          err_count = 0, comparisons = 0, pulses = 0;
  logic [87:0] r;
  // Write address, write data, read address, expected read
  logic [87:0] rows [0:7] = '{{12'h048, 32'h7, 12'h04c, 32'h7}, {12'h04c, 32'h4, 12'h048, 32'h3},
    {12'h048, 32'h0, 12'h04c, 32'h3}, {12'h04c, 32'h2, 12'h04c, 32'h1}, {12'h04c, 32'h1, 12'h048, 32'h0},
    {12'h060, 32'hffffffff, 12'h060, 32'h3f3f}, {12'h060, 32'h0, 12'h060, 32'h3f00},
    {12'h090, 32'hffffffff, 12'h090, 32'h0}};
  assign hready = hreadyout;
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (irq_pulse === 1'b1) pulses++;
  emi_ctrl_regs i_emi_ctrl_regs (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .memory_wait_input(memory_wait_input), .ext_access_active(ext_access_active),
    .line_trap_event(line_trap_event), .irq_pulse(irq_pulse), .flash_mode(flash_mode),
    .parity_start(parity_start), .quad_code_start(quad_code_start), .quad_code_select(quad_code_select),
    .quad_error_locate_start(quad_error_locate_start), .wait_level(wait_level));
  mem_side_model i_mem_side_model (.clk_sys(clk_sys), .access_req(access_req), .stall_cycles(stall_cycles),
    .trap_req(trap_req), .memory_wait_input(memory_wait_input), .ext_access_active(ext_access_active),
    .line_trap_event(line_trap_event));
  // ==========================================
  // Bus and event tasks
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd);
    @(posedge clk_sys);
    hsel <= 1; htrans <= 2'b10; hwrite <= wr; haddr <= a;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel <= 0; htrans <= 2'b00; hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // Output flops trail a register update by one edge; look once both settled
  task automatic settle;
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic access(input logic [7:0] n);
    @(posedge clk_sys);
    stall_cycles <= n; access_req <= 1;
    @(posedge clk_sys);
    access_req <= 0;
    @(posedge clk_sys);
    while (ext_access_active === 1'b1) @(posedge clk_sys);
    // Pulse is registered on the same edge as its flag
    repeat (4) @(posedge clk_sys);
  endtask
  task test_done;
    if (err_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================
  // Sequence
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst <= 0;
    ahb(0, 12'h060, 0, q); `CHK("ctrl reset", 32'h0, q)
    ahb(0, 12'h048, 0, q); `CHK("enable reset", 32'h0, q)
    foreach (rows[i])
    begin
      r = rows[i];
      ahb(1, r[87:76], r[75:44], q);
      ahb(0, r[43:32], 0, q); `CHK("row read", r[31:0], q)
    end
    for (int i = 0; i < 4; i++)
    begin
      ahb(0, 12'h070 + 12'(4 * i), 0, q);
      settle;
      e4 = 4'hf << (i + 1); `CHK("parity start", e4, parity_start)
    end
    `CHK("quad start", 1'b1, quad_code_start)
    ahb(0, 12'h0c8, 0, q);
    settle;
    `CHK("quad start", 1'b0, quad_code_start)
    ahb(0, 12'h0dc, 0, q);
    settle;
    `CHK("locate start", 1'b0, quad_error_locate_start)
    for (int i = 0; i < 4; i++)
    begin
      ahb(1, 12'h060, 32'((i << 4) | (1 << i)), q);
      settle;
      `CHK("quad select", 2'(i), quad_code_select)
      `CHK("flash mode", 4'(1 << i), flash_mode)
    end
    ahb(1, 12'h004, 32'h4, q); ahb(1, 12'h048, 32'h1, q);
    access(8'd12); `CHK("pulses", 1, pulses)
    ahb(0, 12'h040, 0, q); `CHK("raw", 32'h5, q)
    ahb(0, 12'h044, 0, q); `CHK("masked", 32'h1, q)
    ahb(1, 12'h040, 32'h7, q); ahb(0, 12'h040, 0, q); `CHK("raw clear", 32'h0, q)
    ahb(1, 12'h04c, 32'h1, q); access(8'd12);
    ahb(0, 12'h044, 0, q); `CHK("masked off", 32'h0, q)
    `CHK("pulses", 1, pulses)
    ahb(1, 12'h048, 32'h2, q);
    @(posedge clk_sys) trap_req <= 1;
    @(posedge clk_sys) trap_req <= 0;
    repeat (4) @(posedge clk_sys);
    `CHK("pulses", 2, pulses)
    ahb(0, 12'h044, 0, q); `CHK("masked trap", 32'h2, q)
    @(posedge clk_sys) rst <= 1;
    repeat (2) @(posedge clk_sys);
    rst <= 0;
    ahb(0, 12'h048, 0, q); `CHK("enable reset", 32'h0, q)
    ahb(0, 12'h060, 0, q); `CHK("ctrl reset", 32'h0, q)
    test_done;
  end
  initial
  begin
    #500000;
    err_count++;
    test_done;
  end
endmodule // emi_ctrl_regs_tb
